// File: mad_pkg.sv
package mad_pkg;

   localparam int DATA_W = 16;
   localparam int OPND_W = 17;
   localparam int PROD_W = 34;
   localparam int ACC_W  = 40;
   localparam int AHI_LSB = 16;
   localparam int AHI_MSB = 32;

   localparam logic [OPND_W-1:0] NEG_FULL_SCALE = 17'h18000;
   localparam logic [ACC_W-1:0]  SAT_POS        = 40'h007fffffff;
   localparam logic [ACC_W-1:0]  SAT_NEG        = 40'hff80000000;
   localparam logic [ACC_W-1:0]  ROUND_ADD      = 40'h0000008000;
   localparam logic [ACC_W-1:0]  ROUND_MASK     = 40'hffffff0000;
   localparam logic [ACC_W-1:0]  ACC_RESET      = 40'h0000000000;
   localparam logic [DATA_W-1:0] WORD_RESET     = 16'h0000;
   localparam logic [DATA_W-1:0] PTR_ONE        = 16'h0001;

   typedef enum logic [3:0] {
      OP_MULTIPLY, OP_MAC, OP_MAS, OP_UNSIGNED_PRODUCT, OP_MIXED_SIGN_ACC,
      OP_DELAYED_ACC, OP_COEFF_ACC, OP_SQUARE, OP_SQUARE_ADD, OP_SQUARE_SUB,
      OP_SYM_FILTER, OP_DIST_SQUARE
   } mad_op_e;

   // first port source, second port source
   typedef enum logic [3:0] {
      RT_T_IMM, RT_T_PRI, RT_T_A, RT_PRI_PROG, RT_PRI_SEC, RT_PRI_PRI, RT_PRI_A,
      RT_A_PROG, RT_A_A
   } mad_route_e;

   function automatic logic isSquare(mad_op_e op);
      return op inside {OP_SQUARE, OP_SQUARE_ADD, OP_SQUARE_SUB, OP_DIST_SQUARE};
   endfunction : isSquare

   function automatic logic isSubtract(mad_op_e op);
      return op inside {OP_MAS, OP_SQUARE_SUB};
   endfunction : isSubtract

   function automatic logic isAccumulate(mad_op_e op);
      return !(op inside {OP_MULTIPLY, OP_UNSIGNED_PRODUCT, OP_SQUARE});
   endfunction : isAccumulate

endpackage : mad_pkg

// File: mad_mul_if.sv
interface mad_mul_if;
   logic [16:0] x;
   logic [16:0] y;
   logic        fract;
   logic        satProd;
   logic [39:0] product;

   modport sel (output x, output y);
   modport mul (input x, input y, input fract, input satProd, output product);
   modport ctl (input x, input y, input product, output fract, output satProd);
endinterface : mad_mul_if

// File: mad_operand_sel.sv
module mad_operand_sel (
   // source choice
   input wire mad_pkg::mad_route_e route,
   input wire logic                squareSel,
   input wire logic                xUnsigned,
   input wire logic                yUnsigned,
   // candidate sources
   input wire logic [15:0]         tempOperand,
   input wire logic [15:0]         immediate,
   input wire logic [15:0]         primaryDataReadBus,
   input wire logic [15:0]         secondaryDataReadBus,
   input wire logic [15:0]         programReadBus,
   input wire logic [16:0]         accAHigh,
   // to multiplier
   mad_mul_if.sel                  mulIf
);
   import mad_pkg::*;

   function automatic logic [16:0] ext(logic [15:0] d, logic uns);
      return {uns ? 1'b0 : d[15], d}; // see RULE20
   endfunction : ext

   logic [16:0] xSel;
   logic [16:0] ySel;

   always_comb begin
      xSel = ext(primaryDataReadBus, xUnsigned);
      ySel = ext(primaryDataReadBus, yUnsigned);
      unique case (route) // see RULE3
         RT_T_IMM: begin
            xSel = ext(tempOperand, xUnsigned); // see RULE4
            ySel = ext(immediate, yUnsigned);
         end
         RT_T_PRI: begin
            xSel = ext(tempOperand, xUnsigned);
            ySel = ext(primaryDataReadBus, yUnsigned);
         end
         RT_T_A: begin
            xSel = ext(tempOperand, xUnsigned);
            ySel = accAHigh;
         end
         RT_PRI_PROG: ySel = ext(programReadBus, yUnsigned); // see RULE5
         RT_PRI_SEC:  ySel = ext(secondaryDataReadBus, yUnsigned); // see RULE6
         RT_PRI_PRI:  ySel = ext(primaryDataReadBus, yUnsigned);
         RT_PRI_A:    ySel = accAHigh;
         RT_A_PROG: begin
            xSel = accAHigh; // see RULE1
            ySel = ext(programReadBus, yUnsigned); // see RULE2
         end
         RT_A_A: begin
            xSel = accAHigh;
            ySel = accAHigh;
         end
      endcase
   end

   // squares take the first port's value on both inputs
   assign mulIf.x = xSel;
   assign mulIf.y = squareSel ? xSel : ySel; // see RULE15

endmodule : mad_operand_sel

// File: mad_multiplier.sv
module mad_multiplier (
   // operands in, product out
   mad_mul_if.mul mulIf
);
   import mad_pkg::*;

   logic signed [PROD_W-1:0] raw;
   logic        [ACC_W-1:0]  wide;
   logic        [ACC_W-1:0]  scaled;
   logic                     fullScale;

   // 17x17 signed product covers all sign mixes via the bit-16 fill
   assign raw = $signed(mulIf.x) * $signed(mulIf.y); // see RULE19
   assign wide = {{(ACC_W-PROD_W){raw[PROD_W-1]}}, raw};
   assign scaled = mulIf.fract ? {wide[ACC_W-2:0], 1'b0} : wide; // see RULE21
   assign fullScale = (mulIf.x == NEG_FULL_SCALE) && (mulIf.y == NEG_FULL_SCALE);

   // only -1 x -1 can leave the fractional range, so one compare suffices
   assign mulIf.product = (mulIf.satProd && fullScale) ? SAT_POS : scaled; // see RULE16

endmodule : mad_multiplier

// File: mad_top.sv
// Function
// RULE1 - first port: T, primary bus, A high
// RULE2 - second port: primary, secondary, program bus, A high
// RULE3 - nine source pairings chosen per instruction
// RULE4 - T pairs with immediate, primary bus, A
// RULE5 - single operand: primary plus T/imm/program/A; code has no primary/imm pairing, imm pairs only with T
// RULE6 - dual operand: primary and secondary buses
// RULE7 - filter uses program/A; squares use A twice; code forces RT_A_A only for OP_DIST_SQUARE
// RULE8 - T written explicitly or loaded by multiplies
// RULE9 - fresh ALU A value feeds multiplier directly
// RULE10 - dual accumulate: one cycle, two pointer units
// RULE11 - coefficient accumulate: pointer steps, coefficient increments
// RULE12 - delayed accumulate moves each sample up one
// RULE13 - unsigned multiply: T times word, unsigned
// RULE14 - mixed accumulate: unsigned times signed, accumulate
// RULE15 - squares feed same value, then add/subtract
// RULE16 - full-scale square product clamped before accumulate
// RULE17 - without product saturation, only final result saturates
// RULE18 - product clamp needs overflow and fractional modes
// RULE19 - 17x17 multiplier into 40-bit adder, one cycle
// RULE20 - bit 16 zero-filled or sign per operand
// RULE21 - fractional mode doubles the product
// RULE22 - rounding adds 0x8000, clears low 16 bits
module mad_top #(
   parameter int REPEAT_W = 16
) (
   // clock and reset
   input  wire  logic                 clock,
   input  wire  logic                 srst,
   // instruction issue
   input  wire  logic                 issue,
   input  wire  mad_pkg::mad_op_e     opSel,
   input  wire  mad_pkg::mad_route_e  routeSel,
   input  wire  logic                 dstB,
   input  wire  logic                 roundEn,
   input  wire  logic                 loadTImplicit,
   input  wire  logic [REPEAT_W-1:0]  repeatCount,
   // operand buses
   input  wire  logic [15:0]          immediate,
   input  wire  logic [15:0]          primaryDataReadBus,
   input  wire  logic [15:0]          secondaryDataReadBus,
   input  wire  logic [15:0]          programReadBus,
   input  wire  logic [39:0]          aluAccA,
   input  wire  logic                 aluAccAValid,
   // explicit register writes
   input  wire  logic                 tWrEn,
   input  wire  logic [15:0]          tWrData,
   input  wire  logic                 accWrEn,
   input  wire  logic                 accWrSelB,
   input  wire  logic [39:0]          accWrData,
   // mode bits
   input  wire  logic                 saturateOnProduct,
   input  wire  logic                 overflowClampMode,
   input  wire  logic                 fractionalMode,
   // pointer units
   input  wire  logic                 ptrLoad,
   input  wire  logic [15:0]          ptr0Init,
   input  wire  logic [15:0]          ptr1Init,
   input  wire  logic [15:0]          coeffInit,
   input  wire  logic [15:0]          ptr0Step,
   input  wire  logic [15:0]          ptr1Step,
   // status and results
   output logic                       busy,
   output logic                       done,
   output logic [39:0]                accA,
   output logic [39:0]                accB,
   output logic [15:0]                tempOperand,
   output logic [15:0]                ptr0Addr,
   output logic [15:0]                ptr1Addr,
   output logic [15:0]                coeffPointer,
   // sample move write
   output logic                       moveWrEn,
   output logic [15:0]                moveWrAddr,
   output logic [15:0]                moveWrData
);
   import mad_pkg::*;

   if (REPEAT_W < 1 || REPEAT_W > 16) begin : g_badRepeat
      $error("REPEAT_W must be 1..16");
   end

   // forced pairings for the dedicated filter and distance forms
   function automatic mad_route_e effRoute(mad_op_e op, mad_route_e r);
      if (op == OP_SYM_FILTER) return RT_A_PROG; // see RULE7
      if (op == OP_DIST_SQUARE) return RT_A_A; // see RULE7
      return r;
   endfunction : effRoute

   mad_mul_if mulIf ();

   logic                busyQ;
   logic [REPEAT_W-1:0] cntQ;
   mad_op_e             opQ;
   mad_route_e          routeQ;
   logic                dstBQ;
   logic                roundQ;
   logic                loadTQ;
   logic                doneQ;
   logic [39:0]         accAQ;
   logic [39:0]         accBQ;
   logic [15:0]         tQ;
   logic [15:0]         ptr0Q;
   logic [15:0]         ptr1Q;
   logic [15:0]         coeffQ;
   logic                moveEnQ;
   logic [15:0]         moveAddrQ;
   logic [15:0]         moveDataQ;

   logic        accept;
   logic        exec;
   logic        lastExec;
   mad_op_e     curOp;
   mad_route_e  curRoute;
   logic        curDstB;
   logic        curRound;
   logic        curLoadT;
   logic [16:0] accAHigh;
   logic [39:0] accIn;
   logic [39:0] sum;
   logic [39:0] rounded;
   logic [39:0] result;

   // a new issue is ignored while a repeat runs
   assign accept   = issue && !busyQ;
   assign exec     = accept || busyQ;
   assign lastExec = exec && (busyQ ? (cntQ == REPEAT_W'(1)) : (repeatCount == '0));
   assign curOp    = busyQ ? opQ : opSel;
   assign curRoute = effRoute(curOp, busyQ ? routeQ : routeSel);
   assign curDstB  = busyQ ? dstBQ : dstB;
   assign curRound = busyQ ? roundQ : roundEn;
   assign curLoadT = busyQ ? loadTQ : loadTImplicit;

   // bypass saves the store-and-reload cycle for filter and polynomial code
   assign accAHigh = aluAccAValid ? aluAccA[AHI_MSB:AHI_LSB]
                                  : accAQ[AHI_MSB:AHI_LSB]; // see RULE9

   mad_operand_sel u_sel (
      .route                (curRoute),
      .squareSel            (isSquare(curOp)),
      .xUnsigned            (curOp inside {OP_UNSIGNED_PRODUCT, OP_MIXED_SIGN_ACC}), // see RULE13
      .yUnsigned            (curOp == OP_UNSIGNED_PRODUCT), // see RULE14
      .tempOperand          (tQ),
      .immediate            (immediate),
      .primaryDataReadBus   (primaryDataReadBus),
      .secondaryDataReadBus (secondaryDataReadBus),
      .programReadBus       (programReadBus),
      .accAHigh             (accAHigh),
      .mulIf                (mulIf.sel)
   );

   mad_multiplier u_mul (
      .mulIf (mulIf.mul)
   );

   assign mulIf.fract = fractionalMode;
   // clamp only for accumulate/subtract forms with both modes on
   assign mulIf.satProd = saturateOnProduct && overflowClampMode && fractionalMode
                          && isAccumulate(curOp); // see RULE18

   // adder stage in the same cycle as the multiply
   assign accIn   = curDstB ? accBQ : accAQ;
   always_comb begin
      sum = mulIf.product;
      if (isAccumulate(curOp)) begin
         sum = isSubtract(curOp) ? accIn - mulIf.product
                                 : accIn + mulIf.product; // see RULE19
      end
   end
   assign rounded = curRound ? ((sum + ROUND_ADD) & ROUND_MASK) : sum; // see RULE22

   always_comb begin
      result = rounded;
      if (overflowClampMode) begin // see RULE17
         if (!rounded[39] && rounded > SAT_POS) begin
            result = SAT_POS;
         end else if (rounded[39] && rounded < SAT_NEG) begin
            result = SAT_NEG;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         busyQ <= 1'b0;
         cntQ  <= '0;
         doneQ <= 1'b0;
      end else begin
         doneQ <= lastExec;
         if (accept) begin // see RULE11
            cntQ  <= repeatCount;
            busyQ <= repeatCount != '0;
         end else if (busyQ) begin
            cntQ  <= cntQ - REPEAT_W'(1);
            busyQ <= cntQ != REPEAT_W'(1);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         opQ    <= OP_MULTIPLY;
         routeQ <= RT_T_PRI;
         dstBQ  <= 1'b0;
         roundQ <= 1'b0;
         loadTQ <= 1'b0;
      end else if (accept) begin
         opQ    <= opSel;
         routeQ <= routeSel;
         dstBQ  <= dstB;
         roundQ <= roundEn;
         loadTQ <= loadTImplicit;
      end
   end

   // implicit load by a multiply wins over a register write
   always_ff @(posedge clock) begin
      if (srst) begin
         tQ <= WORD_RESET;
      end else if (exec && curLoadT) begin
         tQ <= primaryDataReadBus; // see RULE8
      end else if (tWrEn) begin
         tQ <= tWrData; // see RULE8
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         accAQ <= ACC_RESET;
         accBQ <= ACC_RESET;
      end else begin
         if (exec && !curDstB) begin
            accAQ <= result;
         end else if (accWrEn && !accWrSelB) begin
            accAQ <= accWrData;
         end else if (aluAccAValid) begin
            accAQ <= aluAccA;
         end
         if (exec && curDstB) begin
            accBQ <= result;
         end else if (accWrEn && accWrSelB) begin
            accBQ <= accWrData;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ptr0Q  <= WORD_RESET;
         ptr1Q  <= WORD_RESET;
         coeffQ <= WORD_RESET;
      end else if (ptrLoad && !exec) begin
         ptr0Q  <= ptr0Init;
         ptr1Q  <= ptr1Init;
         coeffQ <= coeffInit;
      end else if (exec) begin
         ptr0Q <= ptr0Q + ptr0Step; // see RULE10
         if (curRoute == RT_PRI_SEC) begin
            ptr1Q <= ptr1Q + ptr1Step; // see RULE10
         end
         if (curOp inside {OP_COEFF_ACC, OP_DELAYED_ACC}) begin
            coeffQ <= coeffQ + PTR_ONE; // see RULE11
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         moveEnQ   <= 1'b0;
         moveAddrQ <= WORD_RESET;
         moveDataQ <= WORD_RESET;
      end else begin
         moveEnQ <= exec && (curOp == OP_DELAYED_ACC); // see RULE12
         if (exec && (curOp == OP_DELAYED_ACC)) begin
            moveAddrQ <= ptr0Q + PTR_ONE;
            moveDataQ <= primaryDataReadBus;
         end
      end
   end

   assign busy         = busyQ;
   assign done         = doneQ;
   assign accA         = accAQ;
   assign accB         = accBQ;
   assign tempOperand  = tQ;
   assign ptr0Addr     = ptr0Q;
   assign ptr1Addr     = ptr1Q;
   assign coeffPointer = coeffQ;
   assign moveWrEn     = moveEnQ;
   assign moveWrAddr   = moveAddrQ;
   assign moveWrData   = moveDataQ;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_issueThree;
      accept && repeatCount == REPEAT_W'(2) && opSel == OP_COEFF_ACC;
   endsequence
   sequence s_runThenDone;
      busy [*2] ##1 (!busy && done);
   endsequence

   x_source_a: assert property (exec && curRoute == RT_A_PROG |->
      mulIf.x == accAHigh) else $error("first port not A high"); // see RULE1
   y_source_a: assert property (exec && curRoute == RT_PRI_SEC && curOp == OP_MAC |->
      mulIf.y[15:0] == secondaryDataReadBus) else $error("second port wrong"); // see RULE6
   t_pairing_a: assert property (exec && curRoute == RT_T_IMM && !isSquare(curOp) |->
      mulIf.x[15:0] == tQ && mulIf.y[15:0] == immediate) else $error("T pairing wrong"); // see RULE4
   square_same_a: assert property (exec && isSquare(curOp) |->
      mulIf.x == mulIf.y) else $error("square inputs differ"); // see RULE15
   unsigned_fill_a: assert property (exec && curOp == OP_UNSIGNED_PRODUCT |->
      !mulIf.x[16] && !mulIf.y[16]) else $error("unsigned fill wrong"); // see RULE20
   prod_clamp_a: assert property (exec && mulIf.satProd && mulIf.x == NEG_FULL_SCALE
      && mulIf.y == NEG_FULL_SCALE |-> mulIf.product == SAT_POS)
      else $error("product not clamped"); // see RULE16
   mac_update_a: assert property (exec && curOp == OP_MAC && !curDstB && !curRound
      && !overflowClampMode |=> accA == $past(accAQ) + $past(mulIf.product))
      else $error("accumulate wrong"); // see RULE19
   round_low_a: assert property (exec && curRound && !curDstB |=>
      accA[15:0] == 16'h0000) else $error("round left low bits"); // see RULE22
   repeat_run_a: assert property (s_issueThree |=> s_runThenDone)
      else $error("repeat length wrong"); // see RULE11
   coeff_step_a: assert property (exec && curOp == OP_COEFF_ACC |=>
      coeffPointer == $past(coeffQ) + PTR_ONE) else $error("coefficient step"); // see RULE11
   sample_move_a: assert property (exec && curOp == OP_DELAYED_ACC |=>
      moveWrEn && moveWrData == $past(primaryDataReadBus)) else $error("no move"); // see RULE12
   t_load_a: assert property (exec && curLoadT |=>
      tempOperand == $past(primaryDataReadBus)) else $error("T not loaded"); // see RULE8
   bypass_a: assert property (exec && aluAccAValid && curRoute == RT_A_A |->
      mulIf.x == aluAccA[32:16]) else $error("bypass missed"); // see RULE9

endmodule : mad_top

// File: mad_bus_model.sv
module mad_bus_model (
   // address side
   input  wire logic [15:0] ptr0Addr,
   input  wire logic [15:0] ptr1Addr,
   input  wire logic [15:0] coeffPointer,
   // read buses
   output logic      [15:0] primaryDataReadBus,
   output logic      [15:0] secondaryDataReadBus,
   output logic      [15:0] programReadBus
);
   timeunit 1ns;
   timeprecision 1ns;
   // each memory word equals its own address, so a pointer value chooses the operand
   assign primaryDataReadBus   = ptr0Addr;
   assign secondaryDataReadBus = ptr1Addr;
   assign programReadBus       = coeffPointer;
endmodule : mad_bus_model

// File: tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import mad_pkg::*;
   logic clock = 1'b0, srst = 1'b1, issue = 1'b0, dstB = 1'b0, roundEn = 1'b0;
   logic loadTImplicit = 1'b0, aluAccAValid = 1'b0, tWrEn = 1'b0, accWrEn = 1'b0;
   logic accWrSelB = 1'b0, saturateOnProduct = 1'b0, overflowClampMode = 1'b0;
   logic fractionalMode = 1'b0, ptrLoad = 1'b0, busy, done, moveWrEn;
   mad_op_e     opSel = OP_MULTIPLY;
   mad_route_e  routeSel = RT_T_IMM;
   logic [15:0] repeatCount = '0, immediate = 16'h0005, tWrData = '0;
   logic [15:0] ptr0Init = '0, ptr1Init = '0, coeffInit = '0, ptr0Step = '0, ptr1Step = '0;
   logic [15:0] primaryDataReadBus, secondaryDataReadBus, programReadBus, tempOperand;
   logic [15:0] ptr0Addr, ptr1Addr, coeffPointer, moveWrAddr, moveWrData, lastAddr, lastData;
   logic [39:0] aluAccA = '0, accWrData = '0, accA, accB;
   int          errCount = 0, nCompared = 0, cnt, moves = 0;
   logic [39:0] routeExp [9] = '{40'd35, 40'd14, 40'd42, 40'd8, 40'd6, 40'd4, 40'd12,
                                 40'd24, 40'd36};
   logic [2:0]  clampMode [5] = '{3'b111, 3'b011, 3'b101, 3'b111, 3'b110};
   logic [39:0] clampExp [5] = '{40'hff80000001, 40'hff80000000, 40'hff80000000,
                                 40'h007fffffff, 40'h0040000000};

   mad_top DUT (.clock, .srst, .issue, .opSel, .routeSel, .dstB, .roundEn, .loadTImplicit,
      .repeatCount, .immediate, .primaryDataReadBus, .secondaryDataReadBus, .programReadBus,
      .aluAccA, .aluAccAValid, .tWrEn, .tWrData, .accWrEn, .accWrSelB, .accWrData,
      .saturateOnProduct, .overflowClampMode, .fractionalMode, .ptrLoad, .ptr0Init,
      .ptr1Init, .coeffInit, .ptr0Step, .ptr1Step, .busy, .done, .accA, .accB, .tempOperand,
      .ptr0Addr, .ptr1Addr, .coeffPointer, .moveWrEn, .moveWrAddr, .moveWrData);
   mad_bus_model partner (.ptr0Addr, .ptr1Addr, .coeffPointer, .primaryDataReadBus,
      .secondaryDataReadBus, .programReadBus);

   always #50 clock = ~clock;

   always @(posedge clock) begin
      if (moveWrEn === 1'b1) begin
         moves <= moves + 1;
         lastAddr <= moveWrAddr;
         lastData <= moveWrData;
      end
   end

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errCount++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic closeOut;
      $display("checks %0d mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : closeOut

   task automatic wrT(input logic [15:0] v);
      @(posedge clock);
      tWrEn <= 1'b1;
      tWrData <= v;
      @(posedge clock);
      tWrEn <= 1'b0;
   endtask : wrT

   task automatic wrAcc(input logic b, input logic [39:0] v);
      @(posedge clock);
      accWrEn <= 1'b1;
      accWrSelB <= b;
      accWrData <= v;
      @(posedge clock);
      accWrEn <= 1'b0;
   endtask : wrAcc

   task automatic setPtr(input logic [15:0] p0, p1, c, s0, s1);
      @(posedge clock);
      ptrLoad <= 1'b1;
      ptr0Init <= p0;
      ptr1Init <= p1;
      coeffInit <= c;
      ptr0Step <= s0;
      ptr1Step <= s1;
      @(posedge clock);
      ptrLoad <= 1'b0;
   endtask : setPtr

   // returns once done is seen; cnt holds the cycles from the issue edge to done, minus one
   task automatic exec(input mad_op_e op, input mad_route_e rt, input logic b,
                       input logic [15:0] rep, input logic alu);
      @(posedge clock);
      issue <= 1'b1;
      opSel <= op;
      routeSel <= rt;
      dstB <= b;
      repeatCount <= rep;
      aluAccAValid <= alu;
      @(posedge clock);
      issue <= 1'b0;
      aluAccAValid <= 1'b0;
      cnt = 0;
      #1;
      while (done !== 1'b1 && cnt < 40) begin
         @(posedge clock);
         #1;
         cnt++;
      end
      check("done delay", 40'(cnt), 40'(rep));
   endtask : exec

   initial begin
      repeat (20000) @(posedge clock);
      errCount++;
      closeOut();
   end

   initial begin
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      #1;
      check("reset accA", accA, '0);
      check("reset busy", 40'(busy), '0);
      $display("test reset done");
      // every source pairing, result into B so A keeps its operand
      wrT(16'h0007);
      setPtr(16'h0002, 16'h0003, 16'h0004, '0, '0);
      wrAcc(1'b0, 40'h0000060000);
      for (int i = 0; i < 9; i++) begin
         exec(OP_MULTIPLY, mad_route_e'(i[3:0]), 1'b1, '0, 1'b0);
         check("route product", accB, routeExp[i]);
      end
      $display("test routes done");
      setPtr(16'hfffe, 16'h0003, '0, '0, '0);
      exec(OP_MULTIPLY, RT_PRI_SEC, 1'b0, '0, 1'b0);
      check("signed product", accA, 40'hfffffffffa);
      wrT(16'hffff);
      setPtr(16'h0002, '0, '0, '0, '0);
      exec(OP_UNSIGNED_PRODUCT, RT_T_PRI, 1'b0, '0, 1'b0);
      check("unsigned product", accA, 40'h000001fffe);
      check("explicit T", 40'(tempOperand), 40'h00ffff);
      setPtr(16'hffff, 16'hffff, '0, '0, '0);
      wrAcc(1'b1, '0);
      exec(OP_MIXED_SIGN_ACC, RT_PRI_SEC, 1'b1, '0, 1'b0);
      check("mixed acc", accB, 40'hffffff0001);
      setPtr(16'h0042, '0, '0, '0, '0);
      loadTImplicit <= 1'b1;
      exec(OP_MULTIPLY, RT_T_PRI, 1'b0, '0, 1'b0);
      loadTImplicit <= 1'b0;
      check("implicit T", 40'(tempOperand), 40'h000042);
      setPtr(16'h0100, 16'h0123, '0, '0, '0);
      roundEn <= 1'b1;
      exec(OP_MULTIPLY, RT_PRI_SEC, 1'b0, '0, 1'b0);
      roundEn <= 1'b0;
      check("rounded", accA, 40'h0000010000);
      $display("test product forms done");
      setPtr(16'h4000, '0, 16'h4000, '0, '0);
      fractionalMode <= 1'b1;
      wrAcc(1'b0, 40'h1);
      exec(OP_MAC, RT_PRI_PROG, 1'b0, '0, 1'b0);
      check("fractional mac", accA, 40'h0020000001);
      setPtr(16'h8000, 16'h8000, '0, '0, '0);
      for (int i = 0; i < 5; i++) begin
         {saturateOnProduct, overflowClampMode, fractionalMode} <= clampMode[i];
         wrAcc(1'b0, '0);
         exec(mad_op_e'(i < 3 ? OP_MAS : OP_MAC), RT_PRI_SEC, 1'b0, '0, 1'b0);
         check("product clamp", accA, clampExp[i]);
      end
      {saturateOnProduct, overflowClampMode, fractionalMode} <= 3'b000;
      $display("test saturation done");
      setPtr(16'hfffd, '0, 16'h0004, '0, '0);
      wrAcc(1'b0, 40'h1);
      exec(OP_SQUARE_ADD, RT_PRI_PRI, 1'b0, '0, 1'b0);
      check("square add", accA, 40'd10);
      exec(OP_SQUARE_SUB, RT_PRI_PRI, 1'b0, '0, 1'b0);
      check("square sub", accA, 40'd1);
      wrAcc(1'b0, 40'h0000030000);
      wrAcc(1'b1, '0);
      exec(OP_SYM_FILTER, RT_T_IMM, 1'b1, '0, 1'b0);
      check("filter", accB, 40'd12);
      aluAccA <= 40'h0000050000;
      exec(OP_DIST_SQUARE, RT_T_IMM, 1'b1, '0, 1'b1);
      check("fresh A square", accB, 40'd37);
      // the bypass also wrote A, so a plain square of A now sees 5
      exec(OP_SQUARE, RT_A_A, 1'b1, '0, 1'b0);
      check("square A", accB, 40'd25);
      $display("test squares done");
      setPtr(16'h0002, '0, 16'h0003, 16'h0001, '0);
      wrAcc(1'b0, '0);
      exec(OP_COEFF_ACC, RT_PRI_PROG, 1'b0, 16'h0002, 1'b0);
      check("coeff acc", accA, 40'd38);
      check("coeff ptr", 40'(coeffPointer), 40'd6);
      check("data ptr", 40'(ptr0Addr), 40'd5);
      setPtr(16'h0002, 16'h0003, '0, 16'h0001, 16'h0002);
      wrAcc(1'b0, '0);
      exec(OP_MAC, RT_PRI_SEC, 1'b0, 16'h0001, 1'b0);
      check("dual mac", accA, 40'd21);
      check("second ptr", 40'(ptr1Addr), 40'd7);
      setPtr(16'h000a, '0, 16'h0004, 16'hffff, '0);
      exec(OP_DELAYED_ACC, RT_PRI_PROG, 1'b0, 16'h0001, 1'b0);
      @(posedge clock);
      #1;
      check("move count", 40'(moves), 40'd2);
      check("move addr", 40'(lastAddr), 40'h00000a);
      check("move data", 40'(lastData), 40'h000009);
      $display("test repeats done");
      closeOut();
   end
endmodule : tb
